// File: hdl/fdc_cmd_write.sv
// Overview of operation
// - Write gate waits for first loaded byte
// - Write protect low at command start skips write, interrupt
// - Write fault aborts command, sets bit 5
// - Pulse 500 ns FM, 200 ns MFM
// - Device writes address mark patterns itself
// - Early, late or nominal per pulse
// - Shift flags stable over whole pulse
// - Ready low skips type II/III, interrupt
// - Positioning commands ignore ready input
// - Type II/III refresh inner track indicator
// - Force interrupt accepted while busy
// - Busy held while command executes
// - Completion: interrupt, busy clear, error status
// - Eleven commands in four types
// - Sector opcode decode and flag bits
// - Address and track opcode decode
// - Force interrupt opcode with condition bits
// - Request on transfer, drop on load
// - Density input low selects MFM
// - Status read or command clears interrupt
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_write #(
  parameter int SECTOR_BYTES = 256,
  parameter int POS_CYCLES = fdc_pkg::POS_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  input wire logic DENSITY_SELECT_N,
  input wire logic READY,
  input wire logic WRITE_PROTECT_N,
  input wire logic WRITE_FAULT,
  input wire logic INDEX,
  output logic WRITE_GATE_OUT,
  output logic WRITE_PULSE_OUT,
  output logic EARLY_OUT,
  output logic LATE_OUT,
  output logic INNER_TRACK_INDICATOR,
  output logic BYTE_REQUEST,
  output logic COMPLETION_IRQ,
  output logic DIRECTION_OUT
);
  typedef enum logic [2:0] {ST_IDLE, ST_POS, ST_WAIT_BYTE, ST_WRITE, ST_READ} fdc_state_e;
  typedef enum logic [2:0] {PH_SYNC, PH_MARK, PH_DATA, PH_CRC_HI, PH_CRC_LO, PH_TAIL, PH_END,
    PH_TRACK} fdc_phase_e;

  fdc_state_e state_q;
  fdc_phase_e phase_q;
  fdc_pkg::fdc_cmd_e cmd_q;
  fdc_pkg::fdc_cmd_e wr_cmd;
  fdc_pkg::fdc_tx_s tx;
  logic [7:0] cmd_bits_q;
  logic [7:0] track_q;
  logic [7:0] sector_q;
  logic [7:0] data_q;
  logic [7:0] rdata_q;
  logic [3:0] fi_arm_q;
  logic [15:0] crc_q;
  logic [10:0] count_q;
  logic [1:0] sync_q;
  logic [$clog2(POS_CYCLES + 1)-1:0] pos_q;
  logic busy_q;
  logic irq_q;
  logic drq_q;
  logic lost_q;
  logic fault_q;
  logic prot_q;
  logic gate_q;
  logic itt_q;
  logic dir_q;
  logic typ1_q;
  logic ready_q;
  logic index_q;
  logic mfm;
  logic wr_cmd_reg;
  logic wr_data_reg;
  logic rd_status;
  logic accept;
  logic is_fi;
  logic taken;
  logic finish;
  logic abort;
  logic fi_event;
  logic index_rise;

  // Opcode decode from the upper bits of the command word
  function automatic fdc_pkg::fdc_cmd_e decode(input logic [7:0] c);
    fdc_pkg::fdc_cmd_e r;
    r = fdc_pkg::CMD_RESTORE;
    case (c[7:5])
      3'h0: r = c[4] ? fdc_pkg::CMD_SEEK : fdc_pkg::CMD_RESTORE;
      3'h1: r = fdc_pkg::CMD_STEP;
      3'h2: r = fdc_pkg::CMD_STEP_IN;
      3'h3: r = fdc_pkg::CMD_STEP_OUT;
      3'h4: r = fdc_pkg::CMD_RD_SECTOR;
      3'h5: r = fdc_pkg::CMD_WR_SECTOR;
      3'h6: r = c[4] ? fdc_pkg::CMD_FORCE_INT : fdc_pkg::CMD_RD_ADDR;
      3'h7: r = c[4] ? fdc_pkg::CMD_WR_TRACK : fdc_pkg::CMD_RD_TRACK;
      default: r = fdc_pkg::CMD_RESTORE;
    endcase
    return r;
  endfunction

  // Positioning commands form type I
  function automatic logic is_type1(input fdc_pkg::fdc_cmd_e c);
    return c == fdc_pkg::CMD_RESTORE || c == fdc_pkg::CMD_SEEK || c == fdc_pkg::CMD_STEP ||
      c == fdc_pkg::CMD_STEP_IN || c == fdc_pkg::CMD_STEP_OUT;
  endfunction

  // Sixteen-bit check value, msb first, over one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--)
      c = (c[15] ^ b[i]) ? ((c << 1) ^ fdc_pkg::CRC_POLY) : (c << 1);
    return c;
  endfunction

  // Host strobes and command acceptance
  assign mfm = !DENSITY_SELECT_N;
  assign wr_cmd_reg = WR_STB && ADDR == fdc_pkg::ADDR_CMD_STATUS;
  assign wr_data_reg = WR_STB && ADDR == fdc_pkg::ADDR_DATA;
  assign rd_status = RD_STB && ADDR == fdc_pkg::ADDR_CMD_STATUS;
  assign wr_cmd = decode(WDATA);
  assign is_fi = wr_cmd == fdc_pkg::CMD_FORCE_INT;
  assign accept = wr_cmd_reg && (!busy_q || is_fi);
  assign index_rise = INDEX && !index_q;
  assign abort = busy_q && WRITE_FAULT;

  // Armed force-interrupt conditions
  assign fi_event = (fi_arm_q[fdc_pkg::FI_TO_READY] && READY && !ready_q) ||
    (fi_arm_q[fdc_pkg::FI_TO_NOT_READY] && !READY && ready_q) ||
    (fi_arm_q[fdc_pkg::FI_INDEX] && index_rise);

  // Normal end of the running command
  always_comb
  begin
    finish = 1'b0;
    case (state_q)
      ST_POS: finish = (pos_q == '0);
      ST_READ: finish = 1'b1;
      ST_WRITE: finish = taken && (phase_q == PH_END || (phase_q == PH_TRACK && index_q));
      default: finish = 1'b0;
    endcase
  end

  // Byte offered to the encoder for the current phase
  always_comb
  begin
    tx.data = fdc_pkg::FILL_BYTE;
    tx.clk = mfm ? fdc_pkg::CLK_NONE_MISSING : fdc_pkg::CLK_NORMAL;
    case (phase_q)
      PH_SYNC:
      begin
        tx.data = fdc_pkg::MFM_SYNC_BYTE;
        tx.clk = fdc_pkg::MISS_SYNC_A1;
      end
      PH_MARK:
      begin
        tx.data = cmd_bits_q[fdc_pkg::CMD_MARK_SEL] ? fdc_pkg::MARK_DELETED :
          fdc_pkg::MARK_NORMAL;
        if (!mfm)
          tx.clk = fdc_pkg::CLK_MARK;
      end
      PH_DATA: tx.data = drq_q ? fdc_pkg::LOST_BYTE : data_q;
      PH_CRC_HI: tx.data = crc_q[15:8];
      PH_CRC_LO: tx.data = crc_q[7:0];
      PH_TRACK:
      begin
        tx.data = drq_q ? fdc_pkg::LOST_BYTE : data_q;
        if (!drq_q && mfm && data_q == fdc_pkg::TRK_CODE_A1)
        begin
          tx.data = fdc_pkg::MFM_SYNC_BYTE;
          tx.clk = fdc_pkg::MISS_SYNC_A1;
        end
        else if (!drq_q && mfm && data_q == fdc_pkg::TRK_CODE_C2)
        begin
          tx.data = fdc_pkg::MFM_IDX_SYNC;
          tx.clk = fdc_pkg::MISS_SYNC_C2;
        end
        else if (!drq_q && !mfm && data_q >= fdc_pkg::FM_MARK_LO &&
          data_q <= fdc_pkg::FM_MARK_HI)
          tx.clk = fdc_pkg::CLK_MARK;
      end
      default: tx.data = fdc_pkg::FILL_BYTE;
    endcase
  end

  // Input history for edge conditions
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      ready_q <= 1'b0;
      index_q <= 1'b0;
    end
    else
    begin
      ready_q <= READY;
      index_q <= INDEX;
    end
  end

  // Command sequencer
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      state_q <= ST_IDLE;
      cmd_q <= fdc_pkg::CMD_RESTORE;
      cmd_bits_q <= 8'h00;
      busy_q <= 1'b0;
      gate_q <= 1'b0;
      pos_q <= '0;
      typ1_q <= 1'b1;
    end
    else if (accept && is_fi)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      gate_q <= 1'b0;
    end
    else if (accept)
    begin
      cmd_q <= wr_cmd;
      cmd_bits_q <= WDATA;
      typ1_q <= is_type1(wr_cmd);
      if (is_type1(wr_cmd))
      begin
        state_q <= ST_POS;
        busy_q <= 1'b1;
        pos_q <= ($clog2(POS_CYCLES + 1))'(POS_CYCLES);
      end
      else if (!READY)
        state_q <= ST_IDLE;
      else if ((wr_cmd == fdc_pkg::CMD_WR_SECTOR || wr_cmd == fdc_pkg::CMD_WR_TRACK) &&
        !WRITE_PROTECT_N)
        state_q <= ST_IDLE;
      else if (wr_cmd == fdc_pkg::CMD_WR_SECTOR || wr_cmd == fdc_pkg::CMD_WR_TRACK)
      begin
        state_q <= ST_WAIT_BYTE;
        busy_q <= 1'b1;
      end
      else
      begin
        state_q <= ST_READ;
        busy_q <= 1'b1;
      end
    end
    else if (abort || finish)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      gate_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_POS)
        pos_q <= pos_q - 1'b1;
      if (state_q == ST_WAIT_BYTE && wr_data_reg)
      begin
        state_q <= ST_WRITE;
        gate_q <= 1'b1;
      end
    end
  end

  // Write stream phases and check value
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B || state_q != ST_WRITE)
    begin
      phase_q <= (cmd_q == fdc_pkg::CMD_WR_TRACK) ? PH_TRACK : (mfm ? PH_SYNC : PH_MARK);
      sync_q <= 2'h1;
      count_q <= 11'h000;
      crc_q <= fdc_pkg::CRC_PRESET;
    end
    else if (taken)
    begin
      crc_q <= crc_byte(crc_q, tx.data);
      case (phase_q)
        PH_SYNC:
        begin
          sync_q <= sync_q + 2'h1;
          if (sync_q == fdc_pkg::SYNC_COUNT)
            phase_q <= PH_MARK;
        end
        PH_MARK: phase_q <= PH_DATA;
        PH_DATA:
        begin
          count_q <= count_q + 11'h001;
          if (count_q == 11'(SECTOR_BYTES - 1))
            phase_q <= PH_CRC_HI;
        end
        PH_CRC_HI: phase_q <= PH_CRC_LO;
        PH_CRC_LO: phase_q <= PH_TAIL;
        PH_TAIL: phase_q <= PH_END;
        default: phase_q <= phase_q;
      endcase
    end
  end

  // Data request: set on transfer to shifter, cleared by host load
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      drq_q <= 1'b0;
      lost_q <= 1'b0;
    end
    else if (accept)
    begin
      drq_q <= !is_fi && READY && WRITE_PROTECT_N &&
        (wr_cmd == fdc_pkg::CMD_WR_SECTOR || wr_cmd == fdc_pkg::CMD_WR_TRACK);
      if (!is_fi)
        lost_q <= 1'b0;
    end
    else if (state_q == ST_WRITE && taken && (phase_q == PH_DATA || phase_q == PH_TRACK))
    begin
      drq_q <= 1'b1;
      if (drq_q)
        lost_q <= 1'b1;
    end
    else if (wr_data_reg || abort || finish)
      drq_q <= 1'b0;
  end

  // Error flags kept for the completion status
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      fault_q <= 1'b0;
      prot_q <= 1'b0;
    end
    else if (abort)
      fault_q <= 1'b1;
    else if (accept && !is_fi)
    begin
      fault_q <= 1'b0;
      prot_q <= (wr_cmd == fdc_pkg::CMD_WR_SECTOR || wr_cmd == fdc_pkg::CMD_WR_TRACK) &&
        !WRITE_PROTECT_N && READY;
    end
  end

  // Interrupt: a set wins over the status-read clear; an accepted command drops a same-cycle end, fault or event set
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      irq_q <= 1'b0;
      fi_arm_q <= 4'h0;
    end
    else
    begin
      if (accept)
        fi_arm_q <= is_fi ? WDATA[3:0] : 4'h0;
      if (accept && is_fi && WDATA[fdc_pkg::FI_IMMEDIATE])
        irq_q <= 1'b1;
      else if (accept && !is_fi && !is_type1(wr_cmd) && (!READY ||
        (!WRITE_PROTECT_N &&
        (wr_cmd == fdc_pkg::CMD_WR_SECTOR || wr_cmd == fdc_pkg::CMD_WR_TRACK))))
        irq_q <= 1'b1;
      else if (!accept && (finish || abort || fi_event))
        irq_q <= 1'b1;
      else if (rd_status || wr_cmd_reg)
        irq_q <= 1'b0;
    end
  end

  // Track register, head direction and inner track indicator
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      track_q <= 8'h00;
      sector_q <= 8'h00;
      data_q <= 8'h00;
      dir_q <= 1'b0;
      itt_q <= 1'b0;
    end
    else
    begin
      if (WR_STB && ADDR == fdc_pkg::ADDR_TRACK)
        track_q <= WDATA;
      if (WR_STB && ADDR == fdc_pkg::ADDR_SECTOR)
        sector_q <= WDATA;
      if (wr_data_reg)
        data_q <= WDATA;
      if (accept && !is_fi && !is_type1(wr_cmd))
        itt_q <= track_q > fdc_pkg::TRACK_INNER;
      if (state_q == ST_POS && finish)
      begin
        case (cmd_q)
          fdc_pkg::CMD_RESTORE: track_q <= 8'h00;
          fdc_pkg::CMD_SEEK:
          begin
            track_q <= data_q;
            dir_q <= data_q > track_q;
          end
          default:
          begin
            if (cmd_q == fdc_pkg::CMD_STEP_IN || cmd_q == fdc_pkg::CMD_STEP_OUT)
              dir_q <= cmd_q == fdc_pkg::CMD_STEP_IN;
            if (cmd_bits_q[fdc_pkg::CMD_TRACK_UPD])
              track_q <= ((cmd_q == fdc_pkg::CMD_STEP && dir_q) ||
                cmd_q == fdc_pkg::CMD_STEP_IN) ? track_q + 8'h01 : track_q - 8'h01;
          end
        endcase
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B || !RD_STB)
      rdata_q <= 8'h00;
    else
    begin
      case (ADDR)
        fdc_pkg::ADDR_TRACK: rdata_q <= track_q;
        fdc_pkg::ADDR_SECTOR: rdata_q <= sector_q;
        fdc_pkg::ADDR_DATA: rdata_q <= data_q;
        default:
        begin
          rdata_q <= 8'h00;
          rdata_q[fdc_pkg::ST_BUSY] <= busy_q;
          rdata_q[fdc_pkg::ST_DRQ_INDEX] <= typ1_q ? INDEX : drq_q;
          rdata_q[fdc_pkg::ST_LOST_TRK0] <= typ1_q ? (track_q == 8'h00) : lost_q;
          rdata_q[fdc_pkg::ST_FAULT] <= fault_q;
          rdata_q[fdc_pkg::ST_PROTECT] <= prot_q;
          rdata_q[fdc_pkg::ST_NOT_READY] <= !READY;
        end
      endcase
    end
  end

  // Bit cell encoder for the write pulse stream
  fdc_wenc u_wenc (
    .clk(REF_CLK),
    .rst_n(RST_B),
    .run(gate_q),
    .mfm(mfm),
    .tx(tx),
    .taken_q(taken),
    .pulse_q(WRITE_PULSE_OUT),
    .early_q(EARLY_OUT),
    .late_q(LATE_OUT)
  );

  // Registered outputs
  assign RDATA = rdata_q;
  assign WRITE_GATE_OUT = gate_q;
  assign INNER_TRACK_INDICATOR = itt_q;
  assign BYTE_REQUEST = drq_q;
  assign COMPLETION_IRQ = irq_q;
  assign DIRECTION_OUT = dir_q;
endmodule
`default_nettype wire

// File: hdl/fdc_pkg.sv
package fdc_pkg;

  // Register addresses on the host port
  localparam logic [1:0] ADDR_CMD_STATUS = 2'h0;
  localparam logic [1:0] ADDR_TRACK = 2'h1;
  localparam logic [1:0] ADDR_SECTOR = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;

  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DRQ_INDEX = 1;
  localparam int ST_LOST_TRK0 = 2;
  localparam int ST_FAULT = 5;
  localparam int ST_PROTECT = 6;
  localparam int ST_NOT_READY = 7;

  // Command field positions
  localparam int CMD_TRACK_UPD = 4;
  localparam int CMD_MARK_SEL = 0;
  localparam int FI_TO_READY = 0;
  localparam int FI_TO_NOT_READY = 1;
  localparam int FI_INDEX = 2;
  localparam int FI_IMMEDIATE = 3;

  // Byte patterns and clock masks
  localparam logic [7:0] MARK_NORMAL = 8'hFB;
  localparam logic [7:0] MARK_DELETED = 8'hF8;
  localparam logic [7:0] MFM_SYNC_BYTE = 8'hA1;
  localparam logic [7:0] MFM_IDX_SYNC = 8'hC2;
  localparam logic [7:0] CLK_NORMAL = 8'hFF;
  localparam logic [7:0] CLK_MARK = 8'hC7;
  localparam logic [7:0] CLK_NONE_MISSING = 8'h00;
  localparam logic [7:0] MISS_SYNC_A1 = 8'h04;
  localparam logic [7:0] MISS_SYNC_C2 = 8'h08;
  localparam logic [7:0] TRK_CODE_A1 = 8'hF5;
  localparam logic [7:0] TRK_CODE_C2 = 8'hF6;
  localparam logic [7:0] FM_MARK_LO = 8'hF8;
  localparam logic [7:0] FM_MARK_HI = 8'hFE;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] LOST_BYTE = 8'h00;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [1:0] SYNC_COUNT = 2'h3;
  localparam logic [7:0] TRACK_INNER = 8'h2B;
  localparam logic [7:0] FI_OPCODE = 8'hD0;

  // Timing, in ns at the reference clock rate
  localparam int CLK_MHZ = 25;
  localparam int FM_PULSE_NS = 500;
  localparam int MFM_PULSE_NS = 200;
  localparam int FM_CELL_NS = 2000;
  localparam int MFM_CELL_NS = 1000;
  localparam int POS_NS = 4000;
  localparam int FM_PULSE_CYC = (FM_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int MFM_PULSE_CYC = (MFM_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int FM_CELL_CYC = (FM_CELL_NS * CLK_MHZ) / 1000;
  localparam int MFM_CELL_CYC = (MFM_CELL_NS * CLK_MHZ) / 1000;
  localparam int POS_CYC = (POS_NS * CLK_MHZ) / 1000;

  typedef enum logic [3:0] {
    CMD_RESTORE, CMD_SEEK, CMD_STEP, CMD_STEP_IN, CMD_STEP_OUT,
    CMD_RD_SECTOR, CMD_WR_SECTOR, CMD_RD_ADDR, CMD_RD_TRACK,
    CMD_WR_TRACK, CMD_FORCE_INT
  } fdc_cmd_e;

  // One byte for the encoder with its clock pattern (FM) or missing-clock mask (MFM)
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] clk;
  } fdc_tx_s;

endpackage

// File: hdl/fdc_wenc.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_wenc #(
  parameter int FM_CELL = fdc_pkg::FM_CELL_CYC,
  parameter int MFM_CELL = fdc_pkg::MFM_CELL_CYC,
  parameter int FM_PW = fdc_pkg::FM_PULSE_CYC,
  parameter int MFM_PW = fdc_pkg::MFM_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic mfm,
  input wire fdc_pkg::fdc_tx_s tx,
  output logic taken_q,
  output logic pulse_q,
  output logic early_q,
  output logic late_q
);
  logic [7:0] cell_q;
  logic half_q;
  logic [2:0] bit_q;
  logic prev_q;
  logic [7:0] pw_q;
  fdc_pkg::fdc_tx_s sh_q;
  fdc_pkg::fdc_tx_s cur;
  logic cell_start;
  logic cur_bit;
  logic next_bit;
  logic emit;

  // New byte is used directly in the clock cell of its first bit
  assign cell_start = (cell_q == 8'h00);
  assign cur = (bit_q == 3'h7 && !half_q) ? tx : sh_q;
  assign cur_bit = cur.data[bit_q];
  assign next_bit = (bit_q != 3'h0) ? cur.data[bit_q - 3'h1] : 1'b0;

  // Clock cell: FM pattern bit, MFM only between zeros unless masked
  always_comb
  begin
    if (!half_q)
      emit = mfm ? (!prev_q && !cur_bit && !cur.clk[bit_q]) : cur.clk[bit_q];
    else
      emit = cur_bit;
  end

  // Cell and bit sequencing; byte loads at the first cell of bit 7
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      cell_q <= 8'h00;
      half_q <= 1'b0;
      bit_q <= 3'h7;
      prev_q <= 1'b0;
      taken_q <= 1'b0;
      sh_q <= '0;
    end
    else
    begin
      taken_q <= 1'b0;
      if (cell_start)
      begin
        cell_q <= mfm ? 8'(MFM_CELL - 1) : 8'(FM_CELL - 1);
        half_q <= !half_q;
        if (bit_q == 3'h7 && !half_q)
        begin
          sh_q <= tx;
          taken_q <= 1'b1;
        end
        if (half_q)
        begin
          prev_q <= cur_bit;
          bit_q <= bit_q - 3'h1;
        end
      end
      else
        cell_q <= cell_q - 8'h01;
    end
  end

  // Pulse width, with shift flags held for the whole pulse
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      pulse_q <= 1'b0;
      early_q <= 1'b0;
      late_q <= 1'b0;
      pw_q <= 8'h00;
    end
    else if (cell_start && emit)
    begin
      pulse_q <= 1'b1;
      pw_q <= mfm ? 8'(MFM_PW - 1) : 8'(FM_PW - 1);
      early_q <= mfm && half_q && prev_q && !next_bit;
      late_q <= mfm && half_q && !prev_q && next_bit;
    end
    else if (pw_q != 8'h00)
      pw_q <= pw_q - 8'h01;
    else
    begin
      pulse_q <= 1'b0;
      early_q <= 1'b0;
      late_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/fdc_cmd_write_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_write_properties (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic DENSITY_SELECT_N,
  input wire logic READY,
  input wire logic WRITE_FAULT,
  input wire logic WRITE_GATE_OUT,
  input wire logic WRITE_PULSE_OUT,
  input wire logic EARLY_OUT,
  input wire logic LATE_OUT,
  input wire logic BYTE_REQUEST,
  input wire logic COMPLETION_IRQ
);
  logic [4:0] run_q;
  wire logic cmd_w = WR_STB && ADDR == 2'h0;
  // Pulse length in clocks; too long for a repetition count
  always_ff @(posedge REF_CLK)
  begin
    run_q <= (RST_B && WRITE_PULSE_OUT) ? run_q + 5'h01 : 5'h00;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  gate_after_load_a: assert property (
    $rose(WRITE_GATE_OUT) |-> $past(WR_STB && ADDR == 2'h3)) else $error("gate before load");
  pulse_width_a: assert property (
    $fell(WRITE_PULSE_OUT) && WRITE_GATE_OUT |-> run_q == (DENSITY_SELECT_N ? 5'h0D : 5'h05))
    else $error("pulse width wrong");
  shift_one_way_a: assert property (
    (EARLY_OUT || LATE_OUT) |-> WRITE_PULSE_OUT && !(EARLY_OUT && LATE_OUT))
    else $error("bad shift flags");
  shift_steady_a: assert property (
    WRITE_PULSE_OUT && $past(WRITE_PULSE_OUT) |-> $stable({EARLY_OUT, LATE_OUT}))
    else $error("shift flags moved");
  fault_abort_a: assert property (
    WRITE_FAULT && WRITE_GATE_OUT |-> ##[1:2] (!WRITE_GATE_OUT && COMPLETION_IRQ))
    else $error("fault not ending write");
  force_stop_a: assert property (
    cmd_w && WDATA[7:4] == 4'hD |=> !WRITE_GATE_OUT) else $error("force kept gate");
  req_drop_a: assert property (
    BYTE_REQUEST && WR_STB && ADDR == 2'h3 |=> !BYTE_REQUEST) else $error("request stuck");
  gate_end_irq_a: assert property (
    $fell(WRITE_GATE_OUT) && !$past(WR_STB) |-> COMPLETION_IRQ) else $error("no end irq");
  skip_unready_a: assert property (
    cmd_w && WDATA[7] && WDATA[7:4] != 4'hD && !READY && !BYTE_REQUEST && !WRITE_GATE_OUT
    |=> COMPLETION_IRQ && !BYTE_REQUEST) else $error("unready command ran");
  irq_clear_a: assert property (
    COMPLETION_IRQ && RD_STB && ADDR == 2'h0 && !WRITE_GATE_OUT |=> !COMPLETION_IRQ)
    else $error("irq not cleared");
endmodule
bind fdc_cmd_write fdc_cmd_write_properties u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .READY(READY),
  .DENSITY_SELECT_N(DENSITY_SELECT_N), .WRITE_FAULT(WRITE_FAULT),
  .WRITE_GATE_OUT(WRITE_GATE_OUT), .WRITE_PULSE_OUT(WRITE_PULSE_OUT),
  .EARLY_OUT(EARLY_OUT), .LATE_OUT(LATE_OUT), .BYTE_REQUEST(BYTE_REQUEST),
  .COMPLETION_IRQ(COMPLETION_IRQ));
`default_nettype wire

// File: verif/fdc_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model (
  input wire logic clk,
  input wire logic gate,
  input wire logic pulse,
  input wire logic fault_req,
  output logic fault,
  output logic index,
  output int pulses
);
  logic [11:0] rot_q = 12'h000;
  logic pulse_q = 1'b0;
  logic fault_q = 1'b0;
  int cnt = 0;
  // Fault only arises under write current; dropped with the gate
  always @(posedge clk)
  begin
    if (!gate)
      fault_q <= 1'b0;
    else if (fault_req)
      fault_q <= 1'b1;
  end
  // Free-running spindle, one turn per 4000 clocks; index outlasts an FM byte
  always @(posedge clk)
  begin
    rot_q <= (rot_q == 12'hF9F) ? 12'h000 : rot_q + 12'h001;
    pulse_q <= pulse;
    if (gate && pulse && !pulse_q)
      cnt <= cnt + 1;
  end
  assign index = rot_q < 12'h384;
  assign fault = fault_q;
  assign pulses = cnt;
endmodule
`default_nettype wire

// File: verif/fdc_cmd_write_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_write_tb_top;
  logic REF_CLK = 1'b0;
  logic RST_B, WR_STB, RD_STB, DENSITY_SELECT_N, READY, WRITE_PROTECT_N, fault_req;
  logic [1:0] ADDR;
  logic [7:0] WDATA, RDATA, st;
  logic WRITE_FAULT, INDEX, WRITE_GATE_OUT, WRITE_PULSE_OUT, EARLY_OUT, LATE_OUT;
  logic INNER_TRACK_INDICATOR, BYTE_REQUEST, COMPLETION_IRQ, DIRECTION_OUT;
  int num_errors, n_checks, pulses, p0;
  typedef struct packed { logic [7:0] cmd; logic busy; logic irq; } fdc_row_s;
  // Command, busy seen at once, irq seen at once; drive not ready
  fdc_row_s rows [12] = '{'{8'hD0, 1'b0, 1'b0}, '{8'h80, 1'b0, 1'b1}, '{8'hA1, 1'b0, 1'b1},
    '{8'hC0, 1'b0, 1'b1}, '{8'hE0, 1'b0, 1'b1}, '{8'hF0, 1'b0, 1'b1}, '{8'h08, 1'b1, 1'b0},
    '{8'h18, 1'b1, 1'b0}, '{8'h38, 1'b1, 1'b0}, '{8'h58, 1'b1, 1'b0}, '{8'h78, 1'b1, 1'b0},
    '{8'hD8, 1'b0, 1'b1}};
  always #20 REF_CLK = ~REF_CLK;
  fdc_cmd_write #(.SECTOR_BYTES(4), .POS_CYCLES(4)) DUT (.REF_CLK(REF_CLK), .RST_B(RST_B),
    .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .DENSITY_SELECT_N(DENSITY_SELECT_N), .READY(READY), .WRITE_PROTECT_N(WRITE_PROTECT_N),
    .WRITE_FAULT(WRITE_FAULT), .INDEX(INDEX), .WRITE_GATE_OUT(WRITE_GATE_OUT),
    .WRITE_PULSE_OUT(WRITE_PULSE_OUT), .EARLY_OUT(EARLY_OUT), .LATE_OUT(LATE_OUT),
    .INNER_TRACK_INDICATOR(INNER_TRACK_INDICATOR), .BYTE_REQUEST(BYTE_REQUEST),
    .COMPLETION_IRQ(COMPLETION_IRQ), .DIRECTION_OUT(DIRECTION_OUT));
  fdc_drive_model u_drive (.clk(REF_CLK), .gate(WRITE_GATE_OUT), .pulse(WRITE_PULSE_OUT),
    .fault_req(fault_req), .fault(WRITE_FAULT), .index(INDEX), .pulses(pulses));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus write; returns just after the taking edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge REF_CLK);
    WR_STB <= 1'b0;
    #1;
  endtask
  // Bus read; data only stand in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge REF_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge REF_CLK);
    RD_STB <= 1'b0;
    #1;
    st = RDATA;
  endtask
  // Bounded wait on the gate (0) or the byte request (1)
  task automatic wait_sig(input logic which, input logic want);
    int n;
    n = 0;
    while (((which ? BYTE_REQUEST : WRITE_GATE_OUT) !== want) && n < 9000)
    begin
      @(negedge REF_CLK);
      n++;
    end
    if (n == 9000)
    begin
      num_errors++;
      $display("MISMATCH t=%0t wait expired", $time);
    end
  endtask
  // Write command, then the first byte opens the gate
  task automatic start_wr(input logic [7:0] c);
    wr(2'h0, c);
    repeat (20) @(posedge REF_CLK);
    #1;
    chk({6'h00, WRITE_GATE_OUT, BYTE_REQUEST}, 8'h01);
    wr(2'h3, 8'hE5);
    chk({6'h00, WRITE_GATE_OUT, BYTE_REQUEST}, 8'h02);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog, well past the expected run
  initial
  begin
    repeat (40000) @(posedge REF_CLK);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    {RST_B, WR_STB, RD_STB, READY, fault_req, ADDR, WDATA} = '0;
    {DENSITY_SELECT_N, WRITE_PROTECT_N} = 2'h3;
    num_errors = 0;
    n_checks = 0;
    repeat (12) @(posedge REF_CLK);
    #1;
    chk({WRITE_GATE_OUT, WRITE_PULSE_OUT, EARLY_OUT, LATE_OUT, INNER_TRACK_INDICATOR,
      BYTE_REQUEST, COMPLETION_IRQ, DIRECTION_OUT}, 8'h00);
    @(posedge REF_CLK);
    RST_B <= 1'b1;
    foreach (rows[i])
    begin
      wr(2'h0, rows[i].cmd);
      chk({7'h00, COMPLETION_IRQ}, {7'h00, rows[i].irq});
      rd(2'h0);
      chk(st & 8'h81, {1'b1, 6'h00, rows[i].busy});
      repeat (8) @(posedge REF_CLK);
      #1;
      if (i < 11)
      begin
        chk({7'h00, COMPLETION_IRQ}, {7'h00, rows[i].busy});
        chk({7'h00, DIRECTION_OUT}, {7'h00, i == 9});
        rd(2'h0);
        chk({7'h00, COMPLETION_IRQ}, 8'h00);
      end
    end
    @(posedge REF_CLK);
    READY <= 1'b1;
    WRITE_PROTECT_N <= 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      wr(2'h0, c ? 8'hF4 : 8'hA0);
      chk({6'h00, COMPLETION_IRQ, BYTE_REQUEST}, 8'h02);
      rd(2'h0);
      chk(st & 8'h41, 8'h40);
    end
    WRITE_PROTECT_N <= 1'b1;
    for (int d = 0; d < 2; d++)
    begin
      DENSITY_SELECT_N <= d[0];
      wr(2'h1, 8'h2C);
      p0 = pulses;
      start_wr({7'h50, d[0]});
      chk({7'h00, INNER_TRACK_INDICATOR}, 8'h01);
      repeat (3)
      begin
        wait_sig(1'b1, 1'b1);
        wr(2'h3, 8'h5A);
      end
      wait_sig(1'b0, 1'b0);
      chk({7'h00, COMPLETION_IRQ}, 8'h01);
      rd(2'h0);
      chk(st & 8'h61, 8'h00);
      // Pulse count window: marks and missing clocks fixed, check bytes vary
      chk({7'h00, pulses - p0 >= (d ? 93 : 57) && pulses - p0 <= (d ? 111 : 67)},
        8'h01);
    end
    start_wr(8'hA0);
    repeat (100) @(posedge REF_CLK);
    fault_req <= 1'b1;
    @(posedge REF_CLK);
    fault_req <= 1'b0;
    wait_sig(1'b0, 1'b0);
    rd(2'h0);
    chk(st & 8'h21, 8'h20);
    // Track write fed only the opening byte; ends at a byte boundary under index
    start_wr(8'hF4);
    wait_sig(1'b0, 1'b0);
    chk({7'h00, COMPLETION_IRQ}, 8'h01);
    rd(2'h0);
    chk(st & 8'h61, 8'h00);
    start_wr(8'hA0);
    wr(2'h0, 8'h80);
    chk({7'h00, WRITE_GATE_OUT}, 8'h01);
    wr(2'h0, 8'hD0);
    chk({6'h00, WRITE_GATE_OUT, COMPLETION_IRQ}, 8'h00);
    rd(2'h0);
    chk(st & 8'h01, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
